// ===== verilog/dbs_bank_tracker.sv
// Top: pin sync, eight banks, device-wide states, legality checking
`timescale 1ns/10ps
`default_nettype none

module dbs_bank_tracker import dbs_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic a10_i,
  output logic [63:0] bank_state_o,
  output logic all_idle_o,
  output logic dev_busy_o,
  output logic cmd_illegal_o
);

  localparam int RP_D = 3;
  localparam int RP_D_MAX = 5;

  dbs_top_t r_reg;
  dbs_top_t r_next;
  dbs_bank_st_t bank_st [8];
  dbs_bank_st_t tgt_st;
  logic banks_idle;
  logic pall_ok;
  logic exe;
  logic bad;

  dbs_cmd_if cmd_if ();

  // ----------------------------------------------------------------------
  // Decoder and banks
  // ----------------------------------------------------------------------
  dbs_cmd_decode u_dec (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .ce_i (ce_i),
    .cke_i (r_reg.pin_s2[8]),
    .cs_n_i (r_reg.pin_s2[7]),
    .ras_n_i (r_reg.pin_s2[6]),
    .cas_n_i (r_reg.pin_s2[5]),
    .we_n_i (r_reg.pin_s2[4]),
    .ba_i (r_reg.pin_s2[3:1]),
    .a10_i (r_reg.pin_s2[0]),
    .cmd_o (cmd_if.src)
  );

  for (genvar g = 0; g < 8; g++) begin : g_bank
    dbs_bank_fsm #(
      .BANK_ID (3'(g))
    ) u_bank (
      .sys_clk_i (sys_clk_i),
      .rst_n_i (rst_n_i),
      .ce_i (ce_i),
      .cmd_i (cmd_if.snk),
      .state_o (bank_st[g])
    );
  end

  // Larger of a pending hold and a new one
  function automatic logic [7:0] hold(logic [7:0] cur, logic [7:0] req);
    hold = (req > cur) ? req : cur;
  endfunction

  // ----------------------------------------------------------------------
  // Legality
  // ----------------------------------------------------------------------
  always_comb begin
    banks_idle = 1'b1;
    pall_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (bank_st[i] != BS_IDLE) begin
        banks_idle = 1'b0;
      end
      // Mid-activation and auto-precharge banks cannot take precharge
      if (bank_st[i] == BS_ACTV || bank_st[i] == BS_RDAP ||
          bank_st[i] == BS_WRAP) begin
        pall_ok = 1'b0;
      end
    end
    tgt_st = bank_st[cmd_if.ba];
    exe = cmd_if.valid;
    bad = 1'b0;
    if (exe) begin
      if (r_reg.mode != M_NORM) begin
        bad = 1'b1;
      end else begin
        unique case (cmd_if.cmd)
          C_REF, C_LMR: begin
            bad = !banks_idle || (r_reg.rd_block != 8'h00) ||
                  (r_reg.wr_block != 8'h00);
          end
          C_ACT: bad = (tgt_st != BS_IDLE);
          C_RD: begin
            bad = !(tgt_st == BS_ROW || tgt_st == BS_RD ||
                    tgt_st == BS_WR) ||
                  (r_reg.rd_block != 8'h00);
          end
          C_WR: begin
            bad = !(tgt_st == BS_ROW || tgt_st == BS_RD ||
                    tgt_st == BS_WR) ||
                  (r_reg.wr_block != 8'h00);
          end
          C_PRE: begin
            if (cmd_if.a10) begin
              bad = !pall_ok;
            end else begin
              bad = (tgt_st == BS_ACTV || tgt_st == BS_RDAP ||
                     tgt_st == BS_WRAP);
            end
          end
          C_RSV: bad = 1'b1;
          C_NOP: bad = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.pin_s1 = {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, a10_i};
    r_next.pin_s2 = r_reg.pin_s1;
    if (r_reg.cnt != 8'h00) begin
      r_next.cnt = r_reg.cnt - 8'h01;
    end
    if (r_reg.rd_block != 8'h00) begin
      r_next.rd_block = r_reg.rd_block - 8'h01;
    end
    if (r_reg.wr_block != 8'h00) begin
      r_next.wr_block = r_reg.wr_block - 8'h01;
    end
    // Cross-bank turnaround holds; banks themselves stay open to others
    if (exe && cmd_if.cmd == C_RD) begin
      r_next.rd_block = hold(r_next.rd_block, BL2_CK - 8'h01);
      r_next.wr_block = hold(r_next.wr_block,
                             RD_TO_WR_CK - 8'h01);
    end
    if (exe && cmd_if.cmd == C_WR) begin
      r_next.rd_block = hold(r_next.rd_block,
                             WR_TO_RD_CK - 8'h01);
      r_next.wr_block = hold(r_next.wr_block, BL2_CK - 8'h01);
    end
    unique case (r_reg.mode)
      M_NORM: begin
        if (exe && !bad) begin
          if (cmd_if.cmd == C_REF) begin
            r_next.mode = M_REF;
            r_next.cnt = RFC_CK - 8'h01;
          end else if (cmd_if.cmd == C_LMR) begin
            r_next.mode = M_MRS;
            r_next.cnt = MRD_CK - 8'h01;
          end else if (cmd_if.cmd == C_PRE && cmd_if.a10) begin
            r_next.mode = M_PALL;
            r_next.cnt = RP_CK - 8'h01;
          end
        end
      end
      M_REF, M_MRS, M_PALL: begin
        // Deselect and NOP simply let the count run
        if (r_reg.cnt == 8'h00) begin
          r_next.mode = M_NORM;
        end
      end
      default: begin
        r_next.mode = M_NORM;
        r_next.cnt = 8'h00;
      end
    endcase
    for (int i = 0; i < 8; i++) begin
      r_next.bank_state[8*i +: 8] = bank_st[i];
    end
    r_next.all_idle = (r_reg.mode == M_NORM) && banks_idle;
    r_next.dev_busy = (r_reg.mode != M_NORM);
    r_next.illegal = exe && bad;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '{pin_s1: 9'h1ff, pin_s2: 9'h1ff, mode: M_NORM,
                 cnt: 8'h00, rd_block: 8'h00, wr_block: 8'h00,
                 bank_state: {8{8'h01}}, all_idle: 1'b0,
                 dev_busy: 1'b0, illegal: 1'b0};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign bank_state_o = r_reg.bank_state;
  assign all_idle_o = r_reg.all_idle;
  assign dev_busy_o = r_reg.dev_busy;
  assign cmd_illegal_o = r_reg.illegal;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  ref_rfc_load_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.mode == M_NORM && exe && !bad && cmd_if.cmd == C_REF)
    |=> (r_reg.mode == M_REF && r_reg.cnt == RFC_CK - 8'h01))
    else $error("refresh did not start its busy period");

  mrs_return_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.mode == M_MRS && r_reg.cnt == 8'h00)
    |=> (r_reg.mode == M_NORM))
    else $error("mode access did not end after its time");

  pall_idle_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.mode == M_NORM && exe && !bad &&
     cmd_if.cmd == C_PRE && cmd_if.a10)
    ##1 (ce_i && !exe) [*4]
    |-> ##[RP_D:RP_D_MAX] (r_reg.mode == M_NORM && banks_idle))
    else $error("banks not idle after precharge all");

  busy_illegal_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.mode != M_NORM && exe) |=> cmd_illegal_o)
    else $error("command during busy state not flagged");

  read_wr_hold_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && exe && cmd_if.cmd == C_RD)
    |=> (r_reg.wr_block >= RD_TO_WR_CK - 8'h01))
    else $error("read did not hold off writes");

  write_rd_hold_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && exe && cmd_if.cmd == C_WR)
    |=> (r_reg.rd_block >= WR_TO_RD_CK - 8'h01))
    else $error("write did not hold off reads");

  idle_out_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.mode == M_NORM && banks_idle) |=> all_idle_o)
    else $error("all idle output missing");

  lm_busy_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && exe && cmd_if.cmd == C_LMR && !banks_idle)
    |=> (cmd_illegal_o && r_reg.mode != M_MRS))
    else $error("mode load with open bank accepted");

endmodule // dbs_bank_tracker

`default_nettype wire

// ===== verilog/dbs_map.svh
// Timing figures and counts for the bank state tracker
//
// Notes on behaviour
// - Precharge holds bank until tRP, then idle
// - Auto-precharge access ends idle after tRP
// - Activate holds bank until tRCD, then active
// - Refresh busy until tRFC, then all idle
// - Mode access busy until tMRD, then idle
// - Precharge all busy until tRP, banks idle
// - Active and idle defined by met timings
// - Read auto-precharge starts at earliest precharge
// - Write auto-precharge starts after write recovery
// - Access period lasts until precharge period
// - Other banks accept commands during auto-precharge
// - Deselect and NOP let operations continue
// - Commands decoded from strobes at clock edge
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define DBS_CLK_PS 5000
`define DBS_T_RP_PS 15000
`define DBS_T_RCD_PS 15000
`define DBS_T_RFC_PS 127500
`define DBS_T_WR_PS 15000
`define DBS_T_WTR_PS 7500
`define DBS_T_MRD_CK 2
`define DBS_WTR_MIN_CK 2
`define DBS_CL 5
`define DBS_BL 8
`define DBS_CEIL_CK(ps) (((ps) + `DBS_CLK_PS - 1) / `DBS_CLK_PS)

`endif

// ===== verilog/dbs_pkg.sv
// Types and derived cycle counts for the bank state tracker
`include "dbs_map.svh"

package dbs_pkg;

  // ----------------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] RP_CK = 8'(`DBS_CEIL_CK(`DBS_T_RP_PS));
  localparam logic [7:0] RCD_CK = 8'(`DBS_CEIL_CK(`DBS_T_RCD_PS));
  localparam logic [7:0] RFC_CK = 8'(`DBS_CEIL_CK(`DBS_T_RFC_PS));
  localparam logic [7:0] WR_CK = 8'(`DBS_CEIL_CK(`DBS_T_WR_PS));
  localparam logic [7:0] MRD_CK = 8'(`DBS_T_MRD_CK);
  localparam logic [7:0] WTR_CK =
    (`DBS_CEIL_CK(`DBS_T_WTR_PS) > `DBS_WTR_MIN_CK) ?
    8'(`DBS_CEIL_CK(`DBS_T_WTR_PS)) : 8'(`DBS_WTR_MIN_CK);
  localparam logic [7:0] BL2_CK = 8'(`DBS_BL / 2);
  localparam logic [7:0] WL_CK = 8'(`DBS_CL - 1);
  localparam logic [7:0] WBURST_CK = WL_CK + BL2_CK;
  localparam logic [7:0] WAP_CK = WL_CK + BL2_CK + WR_CK;
  localparam logic [7:0] RD_TO_WR_CK = BL2_CK + 8'h02;
  localparam logic [7:0] WR_TO_RD_CK = WL_CK + BL2_CK + WTR_CK;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    C_NOP = 3'h0, C_ACT = 3'h1, C_RD = 3'h2, C_WR = 3'h3,
    C_PRE = 3'h4, C_REF = 3'h5, C_LMR = 3'h6, C_RSV = 3'h7
  } dbs_cmd_t;

  typedef enum logic [7:0] {
    BS_IDLE = 8'h01, BS_ACTV = 8'h02, BS_ROW = 8'h04, BS_RD = 8'h08,
    BS_WR = 8'h10, BS_RDAP = 8'h20, BS_WRAP = 8'h40, BS_PRE = 8'h80
  } dbs_bank_st_t;

  typedef enum logic [3:0] {
    M_NORM = 4'h1, M_REF = 4'h2, M_MRS = 4'h4, M_PALL = 4'h8
  } dbs_mode_t;

  typedef struct packed {
    logic cke_prev;
    logic valid;
    dbs_cmd_t cmd;
    logic [2:0] ba;
    logic a10;
  } dbs_dec_t;

  typedef struct packed {
    dbs_bank_st_t st;
    logic [7:0] cnt;
  } dbs_bank_t;

  typedef struct packed {
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    dbs_mode_t mode;
    logic [7:0] cnt;
    logic [7:0] rd_block;
    logic [7:0] wr_block;
    logic [63:0] bank_state;
    logic all_idle;
    logic dev_busy;
    logic illegal;
  } dbs_top_t;

endpackage

// ===== verilog/dbs_cmd_if.sv
// Decoded command carrier between decoder, banks and tracker
`timescale 1ns/10ps
`default_nettype none

interface dbs_cmd_if;
  import dbs_pkg::*;
  logic valid;
  dbs_cmd_t cmd;
  logic [2:0] ba;
  logic a10;
  modport src (output valid, output cmd, output ba, output a10);
  modport snk (input valid, input cmd, input ba, input a10);
endinterface // dbs_cmd_if

`default_nettype wire

// ===== verilog/dbs_cmd_decode.sv
// Command decoder from synchronised strobes
`timescale 1ns/10ps
`default_nettype none

module dbs_cmd_decode import dbs_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic a10_i,
  dbs_cmd_if.src cmd_o
);

  dbs_dec_t r_reg;
  dbs_dec_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.cke_prev = cke_i;
    r_next.cmd = C_NOP;
    r_next.ba = ba_i;
    r_next.a10 = a10_i;
    // Chip select high or NOP yields no command
    if (r_reg.cke_prev && cke_i && !cs_n_i) begin
      unique case ({ras_n_i, cas_n_i, we_n_i})
        3'b011: r_next.cmd = C_ACT;
        3'b101: r_next.cmd = C_RD;
        3'b100: r_next.cmd = C_WR;
        3'b010: r_next.cmd = C_PRE;
        3'b001: r_next.cmd = C_REF;
        3'b000: r_next.cmd = C_LMR;
        3'b110: r_next.cmd = C_RSV;
        3'b111: r_next.cmd = C_NOP;
      endcase
    end
    r_next.valid = (r_next.cmd != C_NOP);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '{cke_prev: 1'b0, valid: 1'b0, cmd: C_NOP, ba: 3'h0,
                 a10: 1'b0};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign cmd_o.valid = r_reg.valid;
  assign cmd_o.cmd = r_reg.cmd;
  assign cmd_o.ba = r_reg.ba;
  assign cmd_o.a10 = r_reg.a10;

endmodule // dbs_cmd_decode

`default_nettype wire

// ===== verilog/dbs_bank_fsm.sv
// One bank's state register and timing down-counter
`timescale 1ns/10ps
`default_nettype none

module dbs_bank_fsm import dbs_pkg::*; #(
  parameter logic [2:0] BANK_ID = 3'h0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  dbs_cmd_if.snk cmd_i,
  output dbs_bank_st_t state_o
);

  dbs_bank_t r_reg;
  dbs_bank_t r_next;
  logic hit;
  logic pre_all;

  // Column or precharge command to an open row
  function automatic dbs_bank_t issue(dbs_cmd_t c, logic ap);
    issue.st = BS_PRE;
    issue.cnt = RP_CK - 8'h01;
    if (c == C_RD) begin
      issue.st = ap ? BS_RDAP : BS_RD;
      issue.cnt = BL2_CK - 8'h01;
    end else if (c == C_WR) begin
      issue.st = ap ? BS_WRAP : BS_WR;
      issue.cnt = ap ? (WAP_CK - 8'h01) : (WBURST_CK - 8'h01);
    end
  endfunction

  assign hit = cmd_i.valid && (cmd_i.ba == BANK_ID);
  assign pre_all = cmd_i.valid && (cmd_i.cmd == C_PRE) && cmd_i.a10;

  always_comb begin
    r_next = r_reg;
    if (r_reg.cnt != 8'h00) begin
      r_next.cnt = r_reg.cnt - 8'h01;
    end
    unique case (r_reg.st)
      BS_IDLE: begin
        if (hit && cmd_i.cmd == C_ACT) begin
          r_next = '{st: BS_ACTV, cnt: RCD_CK - 8'h01};
        end
      end
      BS_ACTV: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.st = BS_ROW;
        end
      end
      BS_ROW, BS_RD, BS_WR: begin
        if (hit && (cmd_i.cmd == C_RD || cmd_i.cmd == C_WR ||
                    cmd_i.cmd == C_PRE)) begin
          r_next = issue(cmd_i.cmd, cmd_i.a10);
        end else if (r_reg.st != BS_ROW && r_reg.cnt == 8'h00) begin
          r_next.st = BS_ROW;
        end
      end
      BS_RDAP, BS_WRAP: begin
        if (r_reg.cnt == 8'h00) begin
          r_next = '{st: BS_PRE, cnt: RP_CK - 8'h01};
        end
      end
      BS_PRE: begin
        if (hit && cmd_i.cmd == C_PRE) begin
          r_next.cnt = RP_CK - 8'h01; // Last precharge sets the period
        end else if (r_reg.cnt == 8'h00) begin
          r_next.st = BS_IDLE;
        end
      end
      default: r_next = '{st: BS_IDLE, cnt: 8'h00};
    endcase
    // Precharge all overrides any open or opening row
    if (pre_all && r_reg.st != BS_IDLE) begin
      r_next = '{st: BS_PRE, cnt: RP_CK - 8'h01};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '{st: BS_IDLE, cnt: 8'h00};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign state_o = r_reg.st;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  act_rcd_load_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.st == BS_IDLE && hit && cmd_i.cmd == C_ACT)
    |=> (r_reg.st == BS_ACTV && r_reg.cnt == RCD_CK - 8'h01))
    else $error("activate did not load row-to-column count");

  rdap_prech_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.st == BS_RDAP && r_reg.cnt == 8'h00)
    |=> (r_reg.st == BS_PRE && r_reg.cnt == RP_CK - 8'h01))
    else $error("read auto precharge did not enter precharge");

  prech_idle_a:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r_reg.st == BS_PRE && r_reg.cnt == 8'h00 &&
     !(hit && cmd_i.cmd == C_PRE) && !pre_all)
    |=> (r_reg.st == BS_IDLE))
    else $error("bank not idle after precharge time");

endmodule // dbs_bank_fsm

`default_nettype wire

// ===== tb/dbs_ctl_model.sv
// Controller-side model turning bench requests into command pins
`timescale 1ns/10ps
`default_nettype none

module dbs_ctl_model import dbs_pkg::*; (
  input wire logic req_v_i,
  input wire dbs_cmd_t req_cmd_i,
  input wire logic [2:0] req_ba_i,
  input wire logic req_a10_i,
  input wire logic [2:0] noise_i,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic a10_o
);
  logic [2:0] code;

  // --------------------
  // Strobe encoding
  // --------------------
  always_comb begin
    case (req_cmd_i)
      C_ACT: code = 3'h3;
      C_RD: code = 3'h5;
      C_WR: code = 3'h4;
      C_PRE: code = 3'h2;
      C_REF: code = 3'h1;
      C_LMR: code = 3'h0;
      C_RSV: code = 3'h6;
      default: code = 3'h7;
    endcase
  end

  // Deselected lines wander so stale values never look like commands
  assign cs_n_o = !req_v_i;
  assign {ras_n_o, cas_n_o, we_n_o} = req_v_i ? code : noise_i;
  assign ba_o = req_v_i ? req_ba_i : ~noise_i;
  assign a10_o = req_v_i ? req_a10_i : noise_i[1];
endmodule // dbs_ctl_model

`default_nettype wire

// ===== tb/ddr2_bank_state_command_rules_test.sv
// Self-checking bench for the bank state tracker
`timescale 1ns/10ps
`default_nettype none

module ddr2_bank_state_command_rules_test import dbs_pkg::*;;
  typedef struct {
    int due;
    int sel;
    int bank;
    logic [7:0] exp;
  } dbs_note_t;

  logic clk;
  logic rst_n;
  logic cke;
  logic req_v;
  dbs_cmd_t req_cmd;
  logic [2:0] req_ba;
  logic req_a10;
  logic [2:0] noise;
  logic cs_n, ras_n, cas_n, we_n, a10;
  logic [2:0] ba;
  logic [63:0] bank_state;
  logic all_idle, dev_busy, illegal;
  int cyc, t0, n_fail, checks, seed;
  logic [2:0] b, b2;
  dbs_note_t notes[$];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  dbs_ctl_model ctl (.req_v_i(req_v), .req_cmd_i(req_cmd),
    .req_ba_i(req_ba), .req_a10_i(req_a10), .noise_i(noise),
    .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .ba_o(ba), .a10_o(a10));

  dbs_bank_tracker DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
    .we_n_i(we_n), .ba_i(ba), .a10_i(a10), .bank_state_o(bank_state),
    .all_idle_o(all_idle), .dev_busy_o(dev_busy),
    .cmd_illegal_o(illegal));

  // --------------------
  // Tasks
  // --------------------
  task automatic end_of_test();
    if (notes.size() != 0) begin
      n_fail++;
    end
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(int sel, int bk, int d, logic [7:0] v);
    notes.push_back('{d, sel, bk, v});
  endtask

  // Expects v0 at the answer edge and at k-1 only, v1 at k
  task automatic span(int sel, int bk, logic [7:0] v0, logic [7:0] v1,
      int k);
    note(sel, bk, t0, v0);
    note(sel, bk, t0 + k - 1, v0);
    note(sel, bk, t0 + k, v1);
  endtask

  // State answer four edges after pin sampling, illegal flag one earlier
  task automatic send(dbs_cmd_t c, logic [2:0] bk, logic ap, logic bad);
    @(posedge clk);
    req_v <= 1'b1;
    req_cmd <= c;
    req_ba <= bk;
    req_a10 <= ap;
    t0 = cyc + 6;
    note(2, 0, t0 - 1, {7'h00, bad});
    @(posedge clk);
    req_v <= 1'b0;
  endtask

  // Extra idle edges keep every cross-bank hold met between tests
  task automatic done(string name);
    repeat (40) if (notes.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
    $display("test %s done", name);
  endtask

  // --------------------
  // Result watcher
  // --------------------
  always @(negedge clk) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        case (notes[i].sel)
          0: check("bank", bank_state[notes[i].bank*8 +: 8], notes[i].exp);
          1: check("busy", {7'h00, dev_busy}, notes[i].exp);
          default: check("illegal", {7'h00, illegal}, notes[i].exp);
        endcase
        notes.delete(i);
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    noise <= 3'($random(seed));
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // --------------------
  // Stimulus
  // --------------------
  initial begin
    rst_n = 1'b0;
    cke = 1'b1;
    req_v = 1'b0;
    req_cmd = C_NOP;
    req_ba = 3'h0;
    req_a10 = 1'b0;
    noise = 3'h0;
    cyc = 0;
    n_fail = 0;
    checks = 0;
    seed = 32'h99ecbf68;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      check("reset bank", bank_state[i*8 +: 8], 8'h01);
    end
    check("all idle", {7'h00, all_idle}, 8'h01);
    b = 3'($random(seed));
    b2 = b ^ 3'h1;
    send(C_ACT, b, 1'b0, 1'b0);
    span(0, b, 8'h02, 8'h04, 3);
    done("activate");
    send(C_RD, b, 1'b0, 1'b0);
    span(0, b, 8'h08, 8'h04, 4);
    done("read");
    send(C_WR, b, 1'b0, 1'b0);
    span(0, b, 8'h10, 8'h04, 8);
    done("write");
    send(C_PRE, b, 1'b0, 1'b0);
    span(0, b, 8'h80, 8'h01, 3);
    done("precharge");
    send(C_ACT, b, 1'b0, 1'b0);
    done("reopen");
    send(C_RD, b, 1'b1, 1'b0);
    span(0, b, 8'h20, 8'h80, 4);
    note(0, b, t0 + 6, 8'h80);
    note(0, b, t0 + 7, 8'h01);
    send(C_ACT, b2, 1'b0, 1'b0);
    span(0, b2, 8'h02, 8'h04, 3);
    done("read autoprecharge");
    send(C_ACT, b, 1'b0, 1'b0);
    done("reopen");
    send(C_RD, b, 1'b0, 1'b0);
    send(C_WR, b2, 1'b0, 1'b1);
    send(C_RD, b, 1'b0, 1'b1);
    done("turnaround");
    send(C_WR, b, 1'b1, 1'b0);
    span(0, b, 8'h40, 8'h80, 11);
    note(0, b, t0 + 13, 8'h80);
    note(0, b, t0 + 14, 8'h01);
    done("write autoprecharge");
    send(C_PRE, b, 1'b1, 1'b0);
    span(1, 0, 8'h01, 8'h00, 3);
    note(0, b2, t0, 8'h80);
    note(0, b2, t0 + 3, 8'h01);
    done("precharge all");
    send(C_REF, b, 1'b0, 1'b0);
    span(1, 0, 8'h01, 8'h00, 26);
    send(C_RSV, b, 1'b0, 1'b1);
    done("refresh");
    send(C_LMR, b, 1'b0, 1'b0);
    span(1, 0, 8'h01, 8'h00, 2);
    done("mode access");
    send(C_ACT, b, 1'b0, 1'b0);
    done("reopen");
    send(C_REF, b2, 1'b0, 1'b1);
    note(1, 0, t0, 8'h00);
    note(2, 0, t0, 8'h00);
    send(C_LMR, b2, 1'b0, 1'b1);
    note(1, 0, t0, 8'h00);
    send(C_RSV, b2, 1'b0, 1'b1);
    send(C_PRE, b, 1'b0, 1'b0);
    span(0, b, 8'h80, 8'h01, 3);
    done("illegal");
    @(posedge clk);
    cke <= 1'b0;
    send(C_ACT, b, 1'b0, 1'b0);
    cke <= 1'b1;
    note(0, b, t0, 8'h01);
    note(0, b, t0 + 3, 8'h01);
    done("clock enable");
    end_of_test();
  end
endmodule // ddr2_bank_state_command_rules_test

`default_nettype wire
